// ===== logic/dpt_pkg.sv
package dpt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam longint TIME_BASE_HZ = 100_000_000;
  localparam longint CORE_CLK_HZ = 50_000_000;
  localparam int TB_TICKS_PER_CLK = int'(TIME_BASE_HZ / CORE_CLK_HZ);
  localparam longint AI_MAX_RATE_SPS = 250_000;
  localparam longint AI_MIN_RATE_MILLI_SPS = 24;
  localparam longint AO_MAX_RATE_SPS = 3_030_303;
  localparam longint EXT_IN_PACE_MAX_HZ = 10_000_000;
  localparam longint EXT_OUT_PACE_MAX_SPS = 3_000_000;
  // Smallest divisors that keep the internal pacers at or under their ceilings
  localparam logic [31:0] AI_MIN_DIV = 32'(TIME_BASE_HZ / AI_MAX_RATE_SPS);
  localparam logic [31:0] AO_MIN_DIV = 32'(TIME_BASE_HZ / AO_MAX_RATE_SPS);
  // Largest divisor the slowest input rate needs; must fit in 32 bits
  localparam longint AI_MAX_DIV = (TIME_BASE_HZ * 1000) / AI_MIN_RATE_MILLI_SPS;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IN_DIV = 8'h04;
  localparam logic [7:0] REG_OUT_DIV = 8'h08;
  localparam logic [7:0] REG_THRESH = 8'h0C;
  localparam logic [7:0] REG_LINE_DIR = 8'h10;
  localparam logic [7:0] REG_LINE_OUT = 8'h14;
  localparam logic [7:0] REG_LINE_IN = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;

  // Reset values
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [31:0] IN_DIV_RST = 32'h0000_0190;
  localparam logic [31:0] OUT_DIV_RST = 32'h0000_0021;
  localparam logic [15:0] THRESH_RST = 16'h8000;
  localparam logic [31:0] LINE_RST = 32'h0000_0000;

  // Status bit positions
  localparam int ST_IN_CONV = 0;
  localparam int ST_OUT_CONV = 1;
  localparam int ST_ACQ_START = 2;
  localparam int ST_ACQ_STOP = 3;
  localparam int ST_ANA_RISE = 4;
  localparam int ST_ANA_FALL = 5;
  localparam int ST_OUT_TRIG = 6;
  localparam int ST_W = 7;

  // External input vector positions
  localparam int EX_IN_PACE = 0;
  localparam int EX_OUT_PACE = 1;
  localparam int EX_TRIG_A = 2;
  localparam int EX_TRIG_B = 3;
  localparam int EX_ANA_A = 4;
  localparam int EX_ANA_B = 5;
  localparam int EX_OUT_TRIG = 6;
  localparam int EX_W = 7;

  // Control register, bit 0 at the bottom
  typedef struct packed {
    logic outRunRequest;   // 9
    logic outTrigNeeded;   // 8
    logic outTrigFalling;  // 7
    logic anaSourceB;      // 6
    logic stopFalling;     // 5
    logic startFalling;    // 4
    logic outPaceEnable;   // 3
    logic inPaceEnable;    // 2
    logic outPaceExternal; // 1
    logic inPaceExternal;  // 0
  } dpt_ctrl_s;

  typedef enum logic [2:0] {
    OUT_IDLE = 3'b001,
    OUT_ARMED = 3'b010,
    OUT_RUN = 3'b100
  } dpt_out_state_e;

endpackage

// ===== logic/dpt_edge_sync.sv
`timescale 1ns/1ps
module dpt_edge_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncLevel,
  output logic [WIDTH-1:0] risePulse,
  output logic [WIDTH-1:0] fallPulse
);

  initial begin
    if (WIDTH < 1) begin
      $error("dpt_edge_sync: WIDTH must be at least 1");
    end
  end

  // Stage one feeds stage two only; edges are taken between stages two and three
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_reg;
    logic stable_reg;
    logic prev_reg;
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        meta_reg <= 1'b0;
        stable_reg <= 1'b0;
        prev_reg <= 1'b0;
      end else begin
        meta_reg <= asyncIn[i];
        stable_reg <= meta_reg;
        prev_reg <= stable_reg;
      end
    end
    assign syncLevel[i] = stable_reg;
    assign risePulse[i] = stable_reg & ~prev_reg;
    assign fallPulse[i] = ~stable_reg & prev_reg;
  end

endmodule

// ===== logic/dpt_pacer_trigger.sv
// Behaviour
// - Input pacer divides the 100 MHz time base by a programmable count.
// - Internal input pacing starts each conversion on the pacer's rising edge.
// - Internal input rate spans 0.024 S/s to 250 kS/s.
// - Software picks internal or external input pacing and the internal rate.
// - External input pacing starts each conversion on the pin's rising edge.
// - A selected edge on either digital trigger pin raises a trigger event.
// - Threshold crossings raise rising or falling analog trigger events.
// - Software writes a 16-bit threshold code spanning -10 V to +10 V.
// - Output update clock divides the 100 MHz time base with 32 bits.
// - Internal output pacing starts each update on the divider's rising edge.
// - Internal output rate stays at or below 3.030303 MS/s; software picks source.
// - External output pacing uses the pin's rising edge, at most 3 MS/s.
// - A digital trigger edge starts continuous output updates.
// - Software selects rising or falling edge for the output trigger.
// - Thirty-two general lines, each set as input or output.
// - Each output update refreshes both output converters together.
// - Start and stop trigger edges are each programmable rising or falling.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module dpt_pacer_trigger #(
  parameter int LINES = 32,
  parameter logic [31:0] IN_MIN_DIV = dpt_pkg::AI_MIN_DIV,
  parameter logic [31:0] OUT_MIN_DIV = dpt_pkg::AO_MIN_DIV
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [dpt_pkg::ADDR_W-1:0] busAddr,
  input wire logic [31:0] busWrData,
  input wire logic busWrStrobe,
  input wire logic busRdStrobe,
  output logic [31:0] busRdData,
  input wire logic inputPaceExt,
  input wire logic outputPaceExt,
  input wire logic digitalTriggerInA,
  input wire logic digitalTriggerInB,
  input wire logic analogThresholdInA,
  input wire logic analogThresholdInB,
  input wire logic outputTriggerIn,
  input wire logic [LINES-1:0] generalLinesIn,
  output logic [LINES-1:0] generalLinesOut,
  output logic [LINES-1:0] generalLinesOe,
  output logic [15:0] thresholdCode,
  output logic inputConvStart,
  output logic [1:0] outputDacUpdate,
  output logic acqStartEvent,
  output logic acqStopEvent,
  output logic anaTrigRise,
  output logic anaTrigFall,
  output logic outputTrigEvent
);
  import dpt_pkg::*;

  initial begin
    if (LINES < 1 || LINES > 32) begin
      $error("dpt_pacer_trigger: LINES must be 1 to 32");
    end
    if (IN_MIN_DIV < 32'(TB_TICKS_PER_CLK) || OUT_MIN_DIV < 32'(TB_TICKS_PER_CLK)) begin
      $error("dpt_pacer_trigger: minimum divisors below one core clock");
    end
    if (AI_MAX_DIV > 64'hFFFF_FFFF) begin
      $error("dpt_pacer_trigger: slowest input rate does not fit the divider");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  dpt_ctrl_s ctrl_reg;
  logic [31:0] inDiv_reg;
  logic [31:0] outDiv_reg;
  logic [15:0] thresh_reg;
  logic [LINES-1:0] lineDir_reg;
  logic [LINES-1:0] lineOut_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] status_next;

  wire selCtrl = busAddr == REG_CTRL;
  wire selInDiv = busAddr == REG_IN_DIV;
  wire selOutDiv = busAddr == REG_OUT_DIV;
  wire selThresh = busAddr == REG_THRESH;
  wire selDir = busAddr == REG_LINE_DIR;
  wire selOut = busAddr == REG_LINE_OUT;
  wire selIn = busAddr == REG_LINE_IN;
  wire selStatus = busAddr == REG_STATUS;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_reg <= dpt_ctrl_s'(CTRL_RST);
      inDiv_reg <= IN_DIV_RST;
      outDiv_reg <= OUT_DIV_RST;
    end else if (busWrStrobe) begin
      if (selCtrl) begin
        ctrl_reg <= dpt_ctrl_s'(busWrData[9:0]);
      end
      if (selInDiv) begin
        inDiv_reg <= busWrData;
      end
      if (selOutDiv) begin
        outDiv_reg <= busWrData;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      thresh_reg <= THRESH_RST;
      lineDir_reg <= LINES'(LINE_RST);
      lineOut_reg <= LINES'(LINE_RST);
    end else if (busWrStrobe) begin
      if (selThresh) begin
        thresh_reg <= busWrData[15:0];
      end
      if (selDir) begin
        lineDir_reg <= busWrData[LINES-1:0];
      end
      if (selOut) begin
        lineOut_reg <= busWrData[LINES-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External inputs
  logic [EX_W-1:0] exRaw;
  logic [EX_W-1:0] exLevel;
  logic [EX_W-1:0] exRise;
  logic [EX_W-1:0] exFall;
  logic [LINES-1:0] lineLevel;

  assign exRaw = {outputTriggerIn, analogThresholdInB, analogThresholdInA, digitalTriggerInB,
                  digitalTriggerInA, outputPaceExt, inputPaceExt};

  dpt_edge_sync #(.WIDTH(EX_W)) u_exSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .asyncIn(exRaw),
    .syncLevel(exLevel),
    .risePulse(exRise),
    .fallPulse(exFall)
  );

  // Lines only need a clean level, the edge outputs are left unused
  dpt_edge_sync #(.WIDTH(LINES)) u_lineSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .asyncIn(generalLinesIn),
    .syncLevel(lineLevel),
    .risePulse(),
    .fallPulse()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pacers: each core clock adds two time-base ticks; the remainder is kept so
  // odd divisors still average to the exact rate, at one core clock of jitter
  logic [32:0] inAcc_reg;
  logic [32:0] outAcc_reg;
  wire [31:0] inDivEff = (inDiv_reg < IN_MIN_DIV) ? IN_MIN_DIV : inDiv_reg;
  wire [31:0] outDivEff = (outDiv_reg < OUT_MIN_DIV) ? OUT_MIN_DIV : outDiv_reg;
  wire [32:0] inAccSum = inAcc_reg + 33'(TB_TICKS_PER_CLK);
  wire [32:0] outAccSum = outAcc_reg + 33'(TB_TICKS_PER_CLK);
  wire inTerminal = inAccSum >= {1'b0, inDivEff};
  wire outTerminal = outAccSum >= {1'b0, outDivEff};
  wire inPacerRun = ctrl_reg.inPaceEnable & ~ctrl_reg.inPaceExternal;
  wire outPacerRun = ctrl_reg.outPaceEnable & ~ctrl_reg.outPaceExternal;

  // A new divisor restarts the phase, so a leftover above it cannot fire every cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n || !inPacerRun || (busWrStrobe && selInDiv)) begin
      inAcc_reg <= 33'h0_0000_0000;
    end else begin
      inAcc_reg <= inTerminal ? inAccSum - {1'b0, inDivEff} : inAccSum;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !outPacerRun || (busWrStrobe && selOutDiv)) begin
      outAcc_reg <= 33'h0_0000_0000;
    end else begin
      outAcc_reg <= outTerminal ? outAccSum - {1'b0, outDivEff} : outAccSum;
    end
  end

  wire inIntTick = inPacerRun & inTerminal;
  wire inExtTick = ctrl_reg.inPaceEnable & ctrl_reg.inPaceExternal & exRise[EX_IN_PACE];
  wire outIntTick = outPacerRun & outTerminal;
  wire outExtTick = ctrl_reg.outPaceEnable & ctrl_reg.outPaceExternal & exRise[EX_OUT_PACE];

  ////////////////////////////////////////////////////////////////////////////
  // Triggers
  wire startHit = ctrl_reg.startFalling ? exFall[EX_TRIG_A] : exRise[EX_TRIG_A];
  wire stopHit = ctrl_reg.stopFalling ? exFall[EX_TRIG_B] : exRise[EX_TRIG_B];
  wire anaRiseHit = ctrl_reg.anaSourceB ? exRise[EX_ANA_B] : exRise[EX_ANA_A];
  wire anaFallHit = ctrl_reg.anaSourceB ? exFall[EX_ANA_B] : exFall[EX_ANA_A];
  wire outTrigHit = ctrl_reg.outTrigFalling ? exFall[EX_OUT_TRIG] : exRise[EX_OUT_TRIG];

  ////////////////////////////////////////////////////////////////////////////
  // Output run control: with a trigger required, updates wait for its edge
  dpt_out_state_e outState_reg;
  dpt_out_state_e outState_next;

  always_comb begin
    outState_next = outState_reg;
    unique case (outState_reg)
      OUT_IDLE: begin
        if (ctrl_reg.outRunRequest) begin
          outState_next = ctrl_reg.outTrigNeeded ? OUT_ARMED : OUT_RUN;
        end
      end
      OUT_ARMED: begin
        if (!ctrl_reg.outRunRequest) begin
          outState_next = OUT_IDLE;
        end else if (outTrigHit) begin
          outState_next = OUT_RUN;
        end
      end
      OUT_RUN: begin
        if (!ctrl_reg.outRunRequest) begin
          outState_next = OUT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      outState_reg <= OUT_IDLE;
    end else begin
      outState_reg <= outState_next;
    end
  end

  wire outUpdateTick = (outState_reg == OUT_RUN) & (outIntTick | outExtTick);

  ////////////////////////////////////////////////////////////////////////////
  // Event outputs and sticky status; a new event beats a clear in the same cycle
  wire [ST_W-1:0] eventVec = {outTrigHit, anaFallHit, anaRiseHit, stopHit, startHit,
                              outUpdateTick, inIntTick | inExtTick};
  wire statusClear = busWrStrobe & selStatus;
  assign status_next = (status_reg & ~(statusClear ? busWrData[ST_W-1:0] : {ST_W{1'b0}})) | eventVec;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_reg <= {ST_W{1'b0}};
      inputConvStart <= 1'b0;
      outputDacUpdate <= 2'b00;
      acqStartEvent <= 1'b0;
      acqStopEvent <= 1'b0;
      anaTrigRise <= 1'b0;
      anaTrigFall <= 1'b0;
      outputTrigEvent <= 1'b0;
    end else begin
      status_reg <= status_next;
      inputConvStart <= eventVec[ST_IN_CONV];
      outputDacUpdate <= {2{eventVec[ST_OUT_CONV]}};
      acqStartEvent <= eventVec[ST_ACQ_START];
      acqStopEvent <= eventVec[ST_ACQ_STOP];
      anaTrigRise <= eventVec[ST_ANA_RISE];
      anaTrigFall <= eventVec[ST_ANA_FALL];
      outputTrigEvent <= eventVec[ST_OUT_TRIG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and read-back
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      generalLinesOut <= LINES'(LINE_RST);
      generalLinesOe <= LINES'(LINE_RST);
      thresholdCode <= THRESH_RST;
    end else begin
      generalLinesOut <= lineOut_reg;
      generalLinesOe <= lineDir_reg;
      thresholdCode <= thresh_reg;
    end
  end

  wire [31:0] rdMux =
    selCtrl ? {22'h00_0000, ctrl_reg} :
    selInDiv ? inDiv_reg :
    selOutDiv ? outDiv_reg :
    selThresh ? {16'h0000, thresh_reg} :
    selDir ? 32'(lineDir_reg) :
    selOut ? 32'(lineOut_reg) :
    selIn ? 32'(lineLevel) :
    selStatus ? {{(32-ST_W){1'b0}}, status_reg} : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busRdData <= 32'h0000_0000;
    end else begin
      busRdData <= busRdStrobe ? rdMux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_inIntPace;
    @(posedge core_clk) disable iff (!rst_n)
      inIntTick |-> ##1 inputConvStart;
  endproperty
  a_inIntPace: assert property (p_inIntPace) else $error("internal input tick lost");

  property p_inExtPace;
    @(posedge core_clk) disable iff (!rst_n)
      (ctrl_reg.inPaceEnable && ctrl_reg.inPaceExternal && $rose(exLevel[EX_IN_PACE]))
        |-> ##1 inputConvStart;
  endproperty
  a_inExtPace: assert property (p_inExtPace) else $error("external input edge lost");

  property p_inRateCap;
    @(posedge core_clk) disable iff (!rst_n)
      inIntTick |-> ##1 !inIntTick [*8];
  endproperty
  a_inRateCap: assert property (p_inRateCap) else $error("input pacer too fast");

  property p_outRateCap;
    @(posedge core_clk) disable iff (!rst_n)
      outIntTick |-> ##1 !outIntTick [*7];
  endproperty
  a_outRateCap: assert property (p_outRateCap) else $error("output pacer too fast");

  property p_dacTogether;
    @(posedge core_clk) disable iff (!rst_n)
      outputDacUpdate[0] == outputDacUpdate[1];
  endproperty
  a_dacTogether: assert property (p_dacTogether) else $error("converters updated apart");

  property p_outNeedsRun;
    @(posedge core_clk) disable iff (!rst_n)
      outputDacUpdate[0] |-> $past(outState_reg) == OUT_RUN;
  endproperty
  a_outNeedsRun: assert property (p_outNeedsRun) else $error("update while not running");

  property p_outTrigStarts;
    @(posedge core_clk) disable iff (!rst_n)
      (outState_reg == OUT_ARMED && ctrl_reg.outRunRequest && outTrigHit) |=> outState_reg == OUT_RUN;
  endproperty
  a_outTrigStarts: assert property (p_outTrigStarts) else $error("output trigger ignored");

  property p_startEdge;
    @(posedge core_clk) disable iff (!rst_n)
      acqStartEvent |-> $past(ctrl_reg.startFalling) ? $fell($past(exLevel[EX_TRIG_A]))
                                                     : $rose($past(exLevel[EX_TRIG_A]));
  endproperty
  a_startEdge: assert property (p_startEdge) else $error("start on wrong edge");

  property p_pulseSingle;
    @(posedge core_clk) disable iff (!rst_n)
      acqStopEvent |=> !acqStopEvent;
  endproperty
  a_pulseSingle: assert property (p_pulseSingle) else $error("stop pulse too long");

  property p_stickySet;
    @(posedge core_clk) disable iff (!rst_n)
      anaRiseHit |=> status_reg[ST_ANA_RISE];
  endproperty
  a_stickySet: assert property (p_stickySet) else $error("analog rise not recorded");

  c_inConv: cover property (@(posedge core_clk) disable iff (!rst_n) inputConvStart);
  c_outRun: cover property (@(posedge core_clk) disable iff (!rst_n)
    outState_reg == OUT_ARMED ##1 outState_reg == OUT_RUN);
  c_anaFall: cover property (@(posedge core_clk) disable iff (!rst_n) anaTrigFall);

endmodule

// ===== testbench/dpt_field_model.sv
`timescale 1ns/1ps
module dpt_field_model (
  input wire logic core_clk,
  input wire logic [31:0] generalLinesOut,
  input wire logic [31:0] generalLinesOe,
  output logic [31:0] generalLinesIn,
  output logic [6:0] pins
);
  import dpt_pkg::*;
  logic [31:0] fieldVal = 32'h0000_0000;
  logic [31:0] fieldOe = 32'h0000_0000;
  int cyc = 0;
  int lastChange [7] = '{default: -100};

  initial pins = 7'h00;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lines that nobody drives float high through the pull-ups
  assign generalLinesIn = (generalLinesOe & generalLinesOut) | (~generalLinesOe & ~fieldOe)
                        | (~generalLinesOe & fieldOe & fieldVal);

  ////////////////////////////////////////////////////////////////////////////
  // Pins move just after a clock edge; the output pacing pin is held longest
  task automatic setPin(input int idx, input logic lvl);
    int gap;
    gap = (idx == EX_OUT_PACE) ? 9 : 3;
    while (cyc < lastChange[idx] + gap) @(posedge core_clk);
    @(posedge core_clk);
    pins[idx] <= lvl;
    lastChange[idx] = cyc;
  endtask

  task automatic driveField(input logic [31:0] val, input logic [31:0] oe);
    @(posedge core_clk);
    fieldVal <= val;
    fieldOe <= oe;
  endtask
endmodule

// ===== testbench/daq_pacer_trigger_control_bench.sv
`timescale 1ns/1ps
module daq_pacer_trigger_control_bench;
  import dpt_pkg::*;
  typedef struct packed {
    logic [9:0] ctrl;
    logic [2:0] pin;
    logic lvl;
    logic [2:0] ev;
    logic hit;
  } dpt_row_s;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] busAddr = 8'h00;
  logic [31:0] busWrData = 32'h0000_0000;
  logic busWrStrobe = 1'b0;
  logic busRdStrobe = 1'b0;
  logic [31:0] busRdData, generalLinesIn, generalLinesOut, generalLinesOe;
  logic [15:0] thresholdCode;
  logic inputConvStart, acqStartEvent, acqStopEvent, anaTrigRise, anaTrigFall, outputTrigEvent;
  logic [1:0] outputDacUpdate;
  logic [6:0] pins;
  wire logic [6:0] evVec;
  int numErrors = 0;
  int comparisons = 0;
  logic [31:0] v, e;
  int n, m;
  // Pin, edge level, event index, whether one pulse is due
  dpt_row_s rows [18] = '{
    '{10'h005, 3'd0, 1'b1, 3'd0, 1'b1}, '{10'h005, 3'd0, 1'b0, 3'd0, 1'b0}, '{10'h001, 3'd0, 1'b1, 3'd0, 1'b0},
    '{10'h20A, 3'd1, 1'b1, 3'd1, 1'b1}, '{10'h00A, 3'd1, 1'b1, 3'd1, 1'b0},
    '{10'h000, 3'd2, 1'b1, 3'd2, 1'b1}, '{10'h010, 3'd2, 1'b0, 3'd2, 1'b1}, '{10'h010, 3'd2, 1'b1, 3'd2, 1'b0},
    '{10'h000, 3'd3, 1'b1, 3'd3, 1'b1}, '{10'h020, 3'd3, 1'b0, 3'd3, 1'b1}, '{10'h020, 3'd3, 1'b1, 3'd3, 1'b0},
    '{10'h000, 3'd4, 1'b1, 3'd4, 1'b1}, '{10'h000, 3'd4, 1'b0, 3'd5, 1'b1}, '{10'h040, 3'd5, 1'b1, 3'd4, 1'b1},
    '{10'h040, 3'd5, 1'b0, 3'd5, 1'b1}, '{10'h000, 3'd5, 1'b1, 3'd4, 1'b0},
    '{10'h300, 3'd6, 1'b1, 3'd6, 1'b1}, '{10'h380, 3'd6, 1'b0, 3'd6, 1'b1}
  };
  logic [7:0] rAddr [9] = '{REG_CTRL, REG_IN_DIV, REG_OUT_DIV, REG_THRESH, REG_LINE_DIR, REG_LINE_OUT,
                            REG_LINE_IN, REG_STATUS, 8'h20};
  logic [31:0] rVal [9] = '{32'h0, IN_DIV_RST, OUT_DIV_RST, 32'h8000, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0};
  logic [31:0] pDiv [6] = '{32'h190, 32'h64, 32'h192, 32'h22, 32'h0A, 32'h42};

  always #10 core_clk = ~core_clk;

  assign evVec = {outputTrigEvent, anaTrigFall, anaTrigRise, acqStopEvent, acqStartEvent, outputDacUpdate[0],
                  inputConvStart};

  dpt_pacer_trigger dpt_pacer_trigger_i (
    .core_clk(core_clk), .rst_n(rst_n), .busAddr(busAddr), .busWrData(busWrData), .busWrStrobe(busWrStrobe),
    .busRdStrobe(busRdStrobe), .busRdData(busRdData), .inputPaceExt(pins[EX_IN_PACE]),
    .outputPaceExt(pins[EX_OUT_PACE]), .digitalTriggerInA(pins[EX_TRIG_A]), .digitalTriggerInB(pins[EX_TRIG_B]),
    .analogThresholdInA(pins[EX_ANA_A]), .analogThresholdInB(pins[EX_ANA_B]), .outputTriggerIn(pins[EX_OUT_TRIG]),
    .generalLinesIn(generalLinesIn), .generalLinesOut(generalLinesOut), .generalLinesOe(generalLinesOe),
    .thresholdCode(thresholdCode), .inputConvStart(inputConvStart), .outputDacUpdate(outputDacUpdate),
    .acqStartEvent(acqStartEvent), .acqStopEvent(acqStopEvent), .anaTrigRise(anaTrigRise),
    .anaTrigFall(anaTrigFall), .outputTrigEvent(outputTrigEvent)
  );

  dpt_field_model dpt_field_model_i (
    .core_clk(core_clk), .generalLinesOut(generalLinesOut), .generalLinesOe(generalLinesOe),
    .generalLinesIn(generalLinesIn), .pins(pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d of %0d comparisons", numErrors, comparisons);
    if (numErrors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic doReset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask

  // One idle cycle between transfers keeps each strobe to one assignment per step
  task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    busAddr <= a;
    busWrData <= d;
    busWrStrobe <= 1'b1;
    @(posedge core_clk);
    busWrStrobe <= 1'b0;
  endtask

  task automatic busRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    busAddr <= a;
    busRdStrobe <= 1'b1;
    @(posedge core_clk);
    busRdStrobe <= 1'b0;
    #1;
    d = busRdData;
  endtask

  task automatic countEv(input int ev, output int k);
    k = 0;
    repeat (10) begin
      @(posedge core_clk);
      #1;
      if (evVec[ev] === 1'b1) k++;
      check(outputDacUpdate[1], outputDacUpdate[0], "converter pair");
    end
  endtask

  task automatic interval(input int ev, output int k);
    int w;
    w = 0;
    #1;
    while (evVec[ev] !== 1'b1 && w < 3000) begin
      @(posedge core_clk);
      #1;
      w++;
    end
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while (evVec[ev] !== 1'b1 && k < 3000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    numErrors++;
    give_verdict();
  end

  initial begin
    doReset();
    busWrite(8'h20, 32'hFFFF_FFFF);
    busWrite(REG_LINE_IN, 32'h0000_0000);
    foreach (rAddr[i]) begin
      busRead(rAddr[i], v);
      check(v, rVal[i], "register readback");
    end
    busRead(REG_IN_DIV, v);
    @(posedge core_clk);
    #1;
    check(busRdData, 32'h0, "read data after its cycle");
    check(thresholdCode, THRESH_RST, "threshold after reset");
    foreach (pDiv[i]) begin
      e = {16'h0, {8{i[0], ~i[0]}}};
      busWrite(REG_THRESH, e);
      busRead(REG_THRESH, v);
      check(v, e, "threshold readback");
      check(thresholdCode, e, "threshold port");
    end
    dpt_field_model_i.driveField(32'h0000_1234, 32'h0000_FFFF);
    busWrite(REG_LINE_DIR, 32'hFFFF_0000);
    busWrite(REG_LINE_OUT, 32'hA5A5_A5A5);
    repeat (4) @(posedge core_clk);
    busRead(REG_LINE_IN, v);
    check(v, 32'hA5A5_1234, "line levels");
    check(generalLinesOe, 32'hFFFF_0000, "line enables");
    check(generalLinesOut, 32'hA5A5_A5A5, "line drive");
    busWrite(REG_OUT_DIV, 32'hFFFF_FFFF);
    busRead(REG_OUT_DIV, v);
    check(v, 32'hFFFF_FFFF, "full width divisor");
    foreach (rows[i]) begin
      busWrite(REG_CTRL, 32'h0);
      dpt_field_model_i.setPin(int'(rows[i].pin), !rows[i].lvl);
      repeat (8) @(posedge core_clk);
      busWrite(REG_CTRL, {22'h0, rows[i].ctrl});
      busWrite(REG_STATUS, 32'h0000_007F);
      dpt_field_model_i.setPin(int'(rows[i].pin), rows[i].lvl);
      countEv(int'(rows[i].ev), n);
      check(n, {31'h0, rows[i].hit}, "event pulses");
      busRead(REG_STATUS, v);
      check(v, rows[i].hit ? (32'h1 << rows[i].ev) : 32'h0, "event status");
    end
    // Two intervals are summed so an odd divisor's alternating spacing still adds up
    foreach (pDiv[i]) begin
      e = (i < 3) ? AI_MIN_DIV : AO_MIN_DIV;
      busWrite(REG_CTRL, 32'h0);
      busWrite((i < 3) ? REG_IN_DIV : REG_OUT_DIV, pDiv[i]);
      busWrite(REG_CTRL, (i < 3) ? 32'h004 : 32'h208);
      interval((i < 3) ? 0 : 1, n);
      interval((i < 3) ? 0 : 1, m);
      check((n + m) * TB_TICKS_PER_CLK, 2 * ((pDiv[i] < e) ? e : pDiv[i]), "pacer period");
      if (i >= 3) check({30'h0, outputDacUpdate}, 32'h3, "both converters");
    end
    busWrite(REG_THRESH, 32'h0000_1111);
    doReset();
    #1;
    check(thresholdCode, THRESH_RST, "threshold after second reset");
    check(generalLinesOe, 32'h0, "lines released by reset");
    give_verdict();
  end
endmodule
